// file: common/zsa_defines.vh
/*
 * Constants of the zone status input assembly: register offsets, status
 * codes, fault word bit positions, thresholds and timing counts.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef ZSA_DEFINES_VH
`define ZSA_DEFINES_VH

// Register offsets, one 16-bit word each.
`define ZSA_OFS_UP_STATE     16'h05dc
`define ZSA_OFS_DN_STATE     16'h05dd
`define ZSA_OFS_UP_ARRIVE    16'h05de
`define ZSA_OFS_UP_DEPART    16'h05df
`define ZSA_OFS_DN_ARRIVE    16'h05e0
`define ZSA_OFS_DN_DEPART    16'h05e1
`define ZSA_OFS_LEFT_FAULT   16'h05e2
`define ZSA_OFS_RIGHT_FAULT  16'h05e3
`define ZSA_NUM_WORDS        4'h8

// Zone status codes.
`define ZSA_CODE_NONE        8'h00
`define ZSA_CODE_CLEAR_STOP  8'h01
`define ZSA_CODE_ACCEPT      8'h02
`define ZSA_CODE_DISCHARGE   8'h04
`define ZSA_CODE_BLOCK_STOP  8'h05
`define ZSA_CODE_BUSY        8'h06

// Fault word bit positions.
`define ZSA_B_RESET          0
`define ZSA_B_OVER_VOLT      2
`define ZSA_B_MOTOR_ERR      3
`define ZSA_B_NET_BAD        4
`define ZSA_B_JAM            5
`define ZSA_B_SENSOR_ERR     6
`define ZSA_B_LOW_VOLT       7
`define ZSA_B_OVER_TEMP      8
`define ZSA_B_OVER_CURR      9
`define ZSA_B_SHORT          10
`define ZSA_B_L_OVERLOAD     11
`define ZSA_B_R_NOT_CONN     11
`define ZSA_B_R_OVERLOAD     12
`define ZSA_B_STALL          13
`define ZSA_B_L_NOT_USED     14
`define ZSA_B_R_HALL_ERR     14
`define ZSA_B_R_NOT_USED     15

// Thresholds, volts, degrees Celsius, and the stall speed divisor.
`define ZSA_OVER_VOLT_V      8'd30
`define ZSA_LOW_VOLT_V       8'd18
`define ZSA_OVER_TEMP_C      8'd105
`define ZSA_STALL_DIV        12'd10

// Timing: overload needs a stall longer than this many seconds.
`define ZSA_CLK_HZ           25000000
`define ZSA_OVERLOAD_S       20
`define ZSA_OVERLOAD_CYCLES  (`ZSA_OVERLOAD_S * `ZSA_CLK_HZ)

`endif

// file: hdl/zsa_assembly.v
/*
 * Zone status input assembly: two zones, two motor side fault words and
 * a read port that streams the eight-word assembly from its first
 * register. Writes are answered with an error and change nothing.
 * Assumes zone sensors arrive from pins; every other input comes from
 * logic on clk. Only one clock, clk, at 25 MHz.
 */
`timescale 1ns/10ps
`include "zsa_defines.vh"

module zsa_assembly #(
  parameter OVERLOAD_CYCLES = `ZSA_OVERLOAD_CYCLES
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  // Zone sensors from pins, bit 0 left, bit 1 right.
  input  wire [1:0]  sensor_pin,
  // Motor control state per side, bit 0 left, bit 1 right.
  input  wire [1:0]  motor_run,
  input  wire [1:0]  motor_rev,
  input  wire [1:0]  network_stop_mode,
  input  wire        single_zone,
  input  wire        single_on_right,
  // Condition inputs.
  input  wire        ctrl_connected,
  input  wire        net_unhealthy,
  input  wire [7:0]  supply_volts,
  input  wire [1:0]  jam,
  input  wire [1:0]  sensor_fault,
  input  wire [7:0]  left_temp_c,
  input  wire [7:0]  right_temp_c,
  input  wire [1:0]  over_current,
  input  wire [1:0]  short_circuit,
  input  wire [7:0]  left_speed,
  input  wire [7:0]  right_speed,
  input  wire [7:0]  left_speed_set,
  input  wire [7:0]  right_speed_set,
  input  wire        right_not_connected,
  input  wire        right_hall_fault,
  input  wire [1:0]  motor_not_used,
  // Read port.
  input  wire        rd_start,
  input  wire [15:0] rd_addr,
  input  wire [3:0]  rd_len,
  output reg         rd_valid,
  output reg  [15:0] rd_data,
  output reg         rd_last,
  output reg         rd_err,
  // Write port.
  input  wire        wr_en,
  input  wire [15:0] wr_addr,
  input  wire [15:0] wr_data,
  output reg         wr_err
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;
  // The limit is cut to the counter width on purpose; 29 bits hold it.
  localparam [31:0] OVL_WIDE  = OVERLOAD_CYCLES;
  localparam [28:0] OVL_LIMIT = OVL_WIDE[28:0];

  // True when the roller runs slower than a tenth of its set speed.
  function slow_roller;
    input [7:0] meas;
    input [7:0] set;
    begin
      slow_roller = ({4'h0, meas} * `ZSA_STALL_DIV) < {4'h0, set};
    end
  endfunction

  // True when the calculated temperature is above the limit.
  function too_hot;
    input [7:0] temp;
    begin
      too_hot = temp > `ZSA_OVER_TEMP_C;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and zone mapping.

  wire [1:0]  sensor_s;
  wire [15:0] up_state;
  wire [15:0] dn_state;
  wire [15:0] up_arrive;
  wire [15:0] up_depart;
  wire [15:0] dn_arrive;
  wire [15:0] dn_depart;
  wire        up_sel;

  zsa_sync #(.W(2)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .pin_in   (sensor_pin),
    .sync_out (sensor_s)
  );

  // A single-zone module reports the used side through upstream.
  assign up_sel = single_zone && single_on_right;

  zsa_zone u_up (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .active     (1'b1),
    .blocked    (sensor_s[up_sel]),
    .motor_run  (motor_run[up_sel]),
    .dir_rev    (motor_rev[up_sel]),
    .net_stop   (network_stop_mode[up_sel]),
    .state_word (up_state),
    .arrivals   (up_arrive),
    .departures (up_depart)
  );

  zsa_zone u_dn (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .active     (!single_zone),
    .blocked    (sensor_s[1]),
    .motor_run  (motor_run[1]),
    .dir_rev    (motor_rev[1]),
    .net_stop   (network_stop_mode[1]),
    .state_word (dn_state),
    .arrivals   (dn_arrive),
    .departures (dn_depart)
  );

  ////////////////////////////////////////////////////////////////////////
  // Stall detection and overload timing per side.

  wire [1:0]  stalled;
  reg  [28:0] ovl_cnt [0:1];
  reg  [1:0]  overload;
  reg         reset_flag;
  integer     s;

  assign stalled[0] = motor_run[0] &&
                      slow_roller(left_speed, left_speed_set);
  assign stalled[1] = motor_run[1] &&
                      slow_roller(right_speed, right_speed_set);

  // Count stalled cycles; overload sets once the limit is passed and clears when the stall ends.
  always @(posedge clk) begin
    if (srst) begin
      for (s = 0; s < 2; s = s + 1) begin
        ovl_cnt[s] <= 29'h0;
      end
      overload <= 2'b00;
    end else if (ce) begin
      for (s = 0; s < 2; s = s + 1) begin
        if (!stalled[s]) begin
          ovl_cnt[s]  <= 29'h0;
          overload[s] <= 1'b0;
        end else if (ovl_cnt[s] > OVL_LIMIT) begin
          overload[s] <= 1'b1;
        end else begin
          ovl_cnt[s] <= ovl_cnt[s] + 29'h1;
        end
      end
    end
  end

  // Reset flag sets with the module reset, clears on connection.
  always @(posedge clk) begin
    if (srst)
      reset_flag <= 1'b1;
    else if (ce && ctrl_connected)
      reset_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault words, built live from the conditions; reserved bits zero.

  wire        over_v;
  wire        low_v;
  reg  [15:0] left_word;
  reg  [15:0] right_word;

  assign over_v = supply_volts > `ZSA_OVER_VOLT_V;
  assign low_v  = supply_volts < `ZSA_LOW_VOLT_V;

  // Left side word.
  always @* begin
    left_word = 16'h0000;
    left_word[`ZSA_B_RESET]      = reset_flag;
    left_word[`ZSA_B_OVER_VOLT]  = over_v;
    left_word[`ZSA_B_NET_BAD]    = net_unhealthy;
    left_word[`ZSA_B_JAM]        = jam[0];
    left_word[`ZSA_B_SENSOR_ERR] = sensor_fault[0];
    left_word[`ZSA_B_LOW_VOLT]   = low_v;
    left_word[`ZSA_B_OVER_TEMP]  = too_hot(left_temp_c);
    left_word[`ZSA_B_OVER_CURR]  = over_current[0];
    left_word[`ZSA_B_SHORT]      = short_circuit[0];
    left_word[`ZSA_B_L_OVERLOAD] = overload[0];
    left_word[`ZSA_B_STALL]      = stalled[0];
    left_word[`ZSA_B_L_NOT_USED] = motor_not_used[0];
    left_word[`ZSA_B_MOTOR_ERR]  = |left_word[15:7];
  end

  // Right side word.
  always @* begin
    right_word = 16'h0000;
    right_word[`ZSA_B_OVER_VOLT]  = over_v;
    right_word[`ZSA_B_JAM]        = jam[1];
    right_word[`ZSA_B_SENSOR_ERR] = sensor_fault[1];
    right_word[`ZSA_B_LOW_VOLT]   = low_v;
    right_word[`ZSA_B_OVER_TEMP]  = too_hot(right_temp_c);
    right_word[`ZSA_B_OVER_CURR]  = over_current[1];
    right_word[`ZSA_B_SHORT]      = short_circuit[1];
    right_word[`ZSA_B_R_NOT_CONN] = right_not_connected;
    right_word[`ZSA_B_R_OVERLOAD] = overload[1];
    right_word[`ZSA_B_STALL]      = stalled[1];
    right_word[`ZSA_B_R_HALL_ERR] = right_hall_fault;
    right_word[`ZSA_B_R_NOT_USED] = motor_not_used[1];
    right_word[`ZSA_B_MOTOR_ERR]  = |right_word[15:7];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read and write port. A read takes a snapshot of all eight words so
  // that one block read is coherent, then streams one word per cycle.

  reg  [15:0] snap [0:7];
  reg  [1:0]  state;
  reg  [2:0]  idx;
  reg  [2:0]  last_idx;
  wire        rd_ok;
  integer     w;

  assign rd_ok = (rd_addr == `ZSA_OFS_UP_STATE) && (rd_len != 4'h0) &&
                 (rd_len <= `ZSA_NUM_WORDS);

  // Read sequencer and answers.
  always @(posedge clk) begin
    if (srst) begin
      state    <= ST_IDLE;
      idx      <= 3'h0;
      last_idx <= 3'h0;
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
      rd_last  <= 1'b0;
      rd_err   <= 1'b0;
      for (w = 0; w < 8; w = w + 1) begin
        snap[w] <= 16'h0000;
      end
    end else if (ce) begin
      rd_valid <= 1'b0;
      rd_last  <= 1'b0;
      rd_err   <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (rd_start && !rd_ok) begin
            rd_err <= 1'b1;
          end else if (rd_start) begin
            snap[0]  <= up_state;
            snap[1]  <= dn_state;
            snap[2]  <= up_arrive;
            snap[3]  <= up_depart;
            snap[4]  <= dn_arrive;
            snap[5]  <= dn_depart;
            snap[6]  <= left_word;
            snap[7]  <= right_word;
            idx      <= 3'h0;
            last_idx <= rd_len[2:0] - 3'h1;
            state    <= ST_SEND;
          end
        end
        ST_SEND: begin
          rd_valid <= 1'b1;
          rd_data  <= snap[idx];
          rd_last  <= (idx == last_idx);
          idx      <= idx + 3'h1;
          if (idx == last_idx)
            state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Every write is refused; no stored value is touched.
  always @(posedge clk) begin
    if (srst)
      wr_err <= 1'b0;
    else if (ce)
      wr_err <= wr_en;
  end

endmodule // zsa_assembly

// file: hdl/zsa_sync.v
/*
 * Two-stage synchroniser for a vector of pin inputs.
 * Assumes the inputs are asynchronous to clk; the first stage feeds only
 * the second.
 */
`timescale 1ns/10ps

module zsa_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         ce,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] stage1;

  // Two flip-flops in series; only the second stage is visible.
  always @(posedge clk) begin
    if (srst) begin
      stage1   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (ce) begin
      stage1   <= pin_in;
      sync_out <= stage1;
    end
  end

endmodule // zsa_sync

// file: hdl/zsa_zone.v
/*
 * One conveyor zone: encodes the zone status word and counts carton
 * arrivals and departures.
 * Assumes a synchronised sensor level and same-clock motor controls.
 */
`timescale 1ns/10ps
`include "zsa_defines.vh"

module zsa_zone (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        active,
  input  wire        blocked,
  input  wire        motor_run,
  input  wire        dir_rev,
  input  wire        net_stop,
  output reg  [15:0] state_word,
  output reg  [15:0] arrivals,
  output reg  [15:0] departures
);

  reg       blocked_d;
  reg [7:0] next_code;

  // Status code from sensor, motor and stop mode; busy overrides all.
  always @* begin
    if (net_stop)
      next_code = `ZSA_CODE_BUSY;
    else if (blocked)
      next_code = motor_run ? `ZSA_CODE_DISCHARGE
                            : `ZSA_CODE_BLOCK_STOP;
    else
      next_code = motor_run ? `ZSA_CODE_ACCEPT
                            : `ZSA_CODE_CLEAR_STOP;
  end

  // Status word, with the code in the byte of the running direction.
  // Counters step on sensor edges and wrap naturally at 16 bits.
  always @(posedge clk) begin
    if (srst) begin
      blocked_d  <= 1'b0;
      state_word <= 16'h0000;
      arrivals   <= 16'h0000;
      departures <= 16'h0000;
    end else if (ce) begin
      blocked_d <= blocked;
      if (!active)
        state_word <= 16'h0000;
      else if (dir_rev)
        state_word <= {next_code, `ZSA_CODE_NONE};
      else
        state_word <= {`ZSA_CODE_NONE, next_code};
      if (active && blocked && !blocked_d)
        arrivals <= arrivals + 16'h0001;
      if (active && !blocked && blocked_d)
        departures <= departures + 16'h0001;
    end
  end

endmodule // zsa_zone

// file: tb/tb_top.sv
/*
 * Testbench of the zone status assembly with a controller model.
 * Assumes a 25 MHz clock and inputs driven on the falling edge.
 */
`timescale 1ns/10ps

module tb_top;
  reg         clk, srst, ce, single_zone, single_on_right;
  reg         ctrl_connected, net_unhealthy, right_not_connected;
  reg         right_hall_fault, wr_en;
  reg  [1:0]  sensor_pin, motor_run, motor_rev, network_stop_mode;
  reg  [1:0]  jam, sensor_fault, over_current, short_circuit;
  reg  [1:0]  motor_not_used;
  reg  [7:0]  supply_volts, left_temp_c, right_temp_c, left_speed;
  reg  [7:0]  right_speed, left_speed_set, right_speed_set;
  reg  [15:0] wr_addr, wr_data;
  wire        rd_start, rd_valid, rd_last, rd_err, wr_err;
  wire [15:0] rd_addr, rd_data;
  wire [3:0]  rd_len;
  integer     num_errors, check_count, cyc, i;
  reg  [15:0] exp [0:7];
  reg  [10:0] tbl [0:5];
  reg  [24:0] rq [0:3];

  zsa_assembly #(.OVERLOAD_CYCLES(20)) dut_u (.clk, .srst, .ce,
    .sensor_pin, .motor_run, .motor_rev, .network_stop_mode, .single_zone,
    .single_on_right, .ctrl_connected, .net_unhealthy, .supply_volts, .jam,
    .sensor_fault, .left_temp_c, .right_temp_c, .over_current,
    .short_circuit, .left_speed, .right_speed, .left_speed_set,
    .right_speed_set, .right_not_connected, .right_hall_fault,
    .motor_not_used, .rd_start, .rd_addr, .rd_len, .rd_valid, .rd_data,
    .rd_last, .rd_err, .wr_en, .wr_addr, .wr_data, .wr_err);
  zsa_plc_model ctl_u (.clk, .rd_valid, .rd_data, .rd_last, .rd_err,
    .rd_start, .rd_addr, .rd_len);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and the hang limit.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end

  // Compares one value and counts the outcome.
  task check(input string name, input [15:0] got, input [15:0] want);
    begin
      check_count = check_count + 1;
      if (got !== want) begin
        num_errors = num_errors + 1;
        $display("ERROR %s exp %h got %h", name, want, got);
      end
    end
  endtask
  task check_words(input integer lo, input integer hi);
    for (int k = lo; k <= hi; k++)
      check($sformatf("word%0d", k), ctl_u.words[k], exp[k]);
  endtask
  task rd_all;
    begin
      ctl_u.read_asm(16'h05dc, 4'h8);
      check("beats", ctl_u.nwords[15:0], 16'h0008);
    end
  endtask
  task settle;
    repeat (6) @(negedge clk);
  endtask
  task set_f(input c, n, input [7:0] v, input [1:0] j, sf,
             input [7:0] lt, rt, input [1:0] oc, sc, input rn, hf,
             input [1:0] nu);
    begin
      ctrl_connected = c;
      net_unhealthy = n;
      supply_volts = v;
      jam = j;
      sensor_fault = sf;
      left_temp_c = lt;
      right_temp_c = rt;
      over_current = oc;
      short_circuit = sc;
      right_not_connected = rn;
      right_hall_fault = hf;
      motor_not_used = nu;
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Main sequence.
  initial begin
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    {srst, ce, single_zone, single_on_right, wr_en} = 5'b11000;
    {sensor_pin, motor_run, motor_rev, network_stop_mode} = 8'h00;
    {wr_addr, wr_data} = 32'h0;
    {left_speed, right_speed, left_speed_set, right_speed_set} = {4{8'd100}};
    set_f(0, 0, 8'd30, 0, 0, 8'd25, 8'd25, 0, 0, 0, 0, 0);
    tbl = '{11'h001, 11'h405, 11'h202, 11'h604, 11'h706, 11'h106};
    rq = '{{16'h05dd, 4'h2, 1'b1, 4'h0}, {16'h05dc, 4'h0, 1'b1, 4'h0},
           {16'h05dc, 4'h9, 1'b1, 4'h0}, {16'h05dc, 4'h1, 1'b0, 4'h1}};
    repeat (10) @(negedge clk);
    srst = 1'b0;
    exp = '{16'h0001, 16'h0001, 0, 0, 0, 0, 16'h0001, 0};
    rd_all;
    check_words(0, 7);
    for (i = 0; i < 3; i++) begin
      sensor_pin = (i < 2) ? 2'b11 : 2'b01;
      settle;
      sensor_pin = 2'b00;
      settle;
    end
    rd_all;
    {exp[2], exp[3], exp[4], exp[5]} = {16'h0003, 16'h0003, 16'h0002,
                                        16'h0002};
    check_words(2, 5);
    for (i = 0; i < 6; i++) begin
      {sensor_pin[0], motor_run[0], network_stop_mode[0]} = tbl[i][10:8];
      settle;
      rd_all;
      check("up_state", ctl_u.words[0], {8'h00, tbl[i][7:0]});
    end
    {network_stop_mode[0], motor_rev[0], sensor_pin[1]} = 3'b011;
    settle;
    rd_all;
    check("up_rev", ctl_u.words[0], 16'h0100);
    check("up_fwd", ctl_u.fwd_code(ctl_u.words[0]), 16'h0000);
    check("dn_state", ctl_u.words[1], 16'h0005);
    {motor_rev[0], single_zone, single_on_right} = 3'b011;
    settle;
    rd_all;
    check("single_up", ctl_u.words[0], 16'h0005);
    check("single_dn", ctl_u.words[1], 16'h0000);
    {single_zone, sensor_pin} = 3'b000;
    set_f(1, 1, 8'd31, 2'b01, 2'b10, 8'd106, 8'd105, 2'b10, 2'b01, 1, 0, 0);
    settle;
    rd_all;
    {exp[6], exp[7]} = {16'h053c, 16'h0a4c};
    check_words(6, 7);
    {wr_en, wr_addr, wr_data} = {1'b1, 16'h05e2, 16'h0000};
    @(negedge clk);
    wr_addr = 16'h05e3;
    @(negedge clk);
    check("wr_err", {15'h0, wr_err}, 16'h0001);
    wr_en = 1'b0;
    rd_all;
    check_words(6, 7);
    // A write while the clock enable is low must not be answered.
    {ce, wr_en} = 2'b01;
    repeat (2) @(negedge clk);
    check("wr_frozen", {15'h0, wr_err}, 16'h0000);
    ce = 1'b1;
    @(negedge clk);
    check("wr_err_ce", {15'h0, wr_err}, 16'h0001);
    wr_en = 1'b0;
    set_f(1, 0, 8'd17, 2'b10, 2'b01, 8'd105, 8'd106, 2'b01, 2'b10, 0, 1, 3);
    settle;
    rd_all;
    {exp[6], exp[7]} = {16'h42c8, 16'hc5a8};
    check_words(6, 7);
    set_f(1, 0, 8'd18, 0, 0, 8'd25, 8'd25, 0, 0, 0, 0, 0);
    {motor_run[1], right_speed} = {1'b1, 8'd9};
    settle;
    rd_all;
    {exp[6], exp[7]} = {16'h0000, 16'h2008};
    check_words(6, 7);
    repeat (30) @(negedge clk);
    rd_all;
    exp[7] = 16'h3008;
    check_words(7, 7);
    right_speed = 8'd10;
    settle;
    rd_all;
    exp[7] = 16'h0000;
    check_words(7, 7);
    // A second reset in mid-run raises the reset flag and clears counters.
    {srst, ctrl_connected} = 2'b10;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rd_all;
    exp = '{16'h0001, 16'h0002, 0, 0, 0, 0, 16'h0001, 0};
    check_words(0, 7);
    for (i = 0; i < 4; i++) begin
      ctl_u.read_asm(rq[i][24:9], rq[i][8:5]);
      check("rd_err", {15'h0, ctl_u.got_err}, {15'h0, rq[i][4]});
      check("beats", ctl_u.nwords[15:0], {12'h0, rq[i][3:0]});
    end
    finish_test;
  end
endmodule // tb_top

// file: tb/zsa_assembly_sva.sv
/*
 * Checker of the read and write ports of the zone status assembly.
 * Assumes ce stays high while a read streams.
 */
`timescale 1ns/10ps

module zsa_assembly_sva (
  input wire        clk,
  input wire        srst,
  input wire        ce,
  input wire        rd_start,
  input wire [15:0] rd_addr,
  input wire [3:0]  rd_len,
  input wire        rd_valid,
  input wire [15:0] rd_data,
  input wire        rd_last,
  input wire        rd_err,
  input wire        wr_en,
  input wire        wr_err
);
  reg        busy_q;
  reg  [2:0] idx;
  wire       idle = !busy_q || (rd_valid && rd_last);
  wire       take = ce && rd_start && idle;
  wire       good = (rd_addr == 16'h05dc) && (rd_len != 4'h0) &&
                    (rd_len <= 4'h8);
  wire [7:0] lo = rd_data[7:0];
  wire [7:0] hi = rd_data[15:8];

  // A legal zone code, or an empty byte.
  function automatic bit code_ok(input [7:0] c);
    code_ok = (c <= 8'h02) || (c >= 8'h04 && c <= 8'h06);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tracks an accepted read and the index of each returned word.
  always @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      idx <= 3'h0;
    end else if (ce) begin
      if (take && good)
        busy_q <= 1'b1;
      else if (rd_valid && rd_last)
        busy_q <= 1'b0;
      if (rd_valid)
        idx <= rd_last ? 3'h0 : idx + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_wr_refuse; (ce && wr_en) |=> wr_err; endproperty
  a_wr_refuse: assert property (p_wr_refuse)
    else $error("write not refused");
  property p_rd_refuse; take && !good |=> rd_err && !rd_valid; endproperty
  a_rd_refuse: assert property (p_rd_refuse)
    else $error("bad read not refused");
  property p_first; take && good |=> !rd_valid ##1 rd_valid; endproperty
  a_first: assert property (p_first)
    else $error("first word late or early");
  property p_len1;
    take && good && rd_len == 4'h1 |=> ##1 rd_valid && rd_last;
  endproperty
  a_len1: assert property (p_len1)
    else $error("one-word read wrong");
  property p_len8;
    take && good && rd_len == 4'h8 |=> ##1 (rd_valid && !rd_last) [*7]
      ##1 (rd_valid && rd_last);
  endproperty
  a_len8: assert property (p_len8)
    else $error("eight-word read wrong");
  property p_codes;
    rd_valid && idx < 3'h2 |-> code_ok(lo) && code_ok(hi) &&
      (lo == 8'h00 || hi == 8'h00);
  endproperty
  a_codes: assert property (p_codes)
    else $error("zone status code illegal");
  property p_rsv_left; rd_valid && idx == 3'h6 |-> !rd_data[1]; endproperty
  a_rsv_left: assert property (p_rsv_left)
    else $error("left reserved bit set");
  property p_rsv_right;
    rd_valid && idx == 3'h7 |-> (rd_data & 16'h0013) == 16'h0000;
  endproperty
  a_rsv_right: assert property (p_rsv_right)
    else $error("right reserved bit set");
  property p_err_sum;
    rd_valid && idx >= 3'h6 |-> rd_data[3] == (|rd_data[15:7]);
  endproperty
  a_err_sum: assert property (p_err_sum)
    else $error("motor error summary wrong");
endmodule // zsa_assembly_sva

bind zsa_assembly zsa_assembly_sva chk_u (.clk, .srst, .ce, .rd_start,
  .rd_addr, .rd_len, .rd_valid, .rd_data, .rd_last, .rd_err, .wr_en,
  .wr_err);

// file: tb/zsa_plc_model.sv
/*
 * Controller model: issues assembly reads and gathers the returned words.
 * Assumes the read port of the zone status assembly on the same clock.
 */
`timescale 1ns/10ps

module zsa_plc_model (
  input  wire        clk,
  input  wire        rd_valid,
  input  wire [15:0] rd_data,
  input  wire        rd_last,
  input  wire        rd_err,
  output reg         rd_start,
  output reg  [15:0] rd_addr,
  output reg  [3:0]  rd_len
);
  reg     [15:0] words [0:7];
  reg            got_err;
  integer        nwords;

  ////////////////////////////////////////////////////////////////////////////
  // Idle request lines at time zero.
  initial begin
    rd_start = 1'b0;
    rd_addr  = 16'h0000;
    rd_len   = 4'h0;
    got_err  = 1'b0;
    nwords   = 0;
  end

  // Single-direction view of a status word: the high byte is dropped.
  function [7:0] fwd_code(input [15:0] w);
    fwd_code = w[7:0];
  endfunction

  // One read: a single-cycle start, then words gathered until the end.
  task read_asm(input [15:0] addr, input [3:0] len);
    integer t;
    reg     fin;
    begin
      nwords = 0;
      got_err = 1'b0;
      fin = 1'b0;
      t = 0;
      @(negedge clk);
      rd_start <= 1'b1;
      rd_addr <= addr;
      rd_len <= len;
      while (!fin && t < 16) begin
        @(negedge clk);
        if (t == 0) begin
          rd_start <= 1'b0;
          rd_addr <= ~addr;
          rd_len <= ~len;
        end
        if (rd_valid === 1'b1 && nwords < 8) begin
          words[nwords] = rd_data;
          nwords = nwords + 1;
        end
        if (rd_err === 1'b1)
          got_err = 1'b1;
        fin = (rd_err === 1'b1) || (rd_last === 1'b1);
        t = t + 1;
      end
    end
  endtask
endmodule // zsa_plc_model
